// file: pkg/psc_pkg.sv
package psc_pkg;
  // Timing
  localparam int CLK_PERIOD_NS = 25;
  localparam int LINK_PERIOD_NS = 200;
  localparam int LINK_HALF_CYC = LINK_PERIOD_NS / (2 * CLK_PERIOD_NS);
  localparam int POR_HOLD_US = 100;
  localparam int POR_CYC = (POR_HOLD_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TRIG_LOW_NS = 2000;
  localparam int TRIG_CYC = (TRIG_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int INIT_CYC = 16;
  // Bitstream
  localparam int CFG_BITS = 64;
  localparam int EXTRA_FALLS = 2;
  localparam int OPT_INIT_IDX = 0;
  localparam int OPT_UIO_IDX = 1;
  localparam int BYTE_W = 8;
  localparam int FIFO_DEPTH = 2;
  // Pin levels
  localparam logic PIN_LO = 1'h0;
  localparam logic PIN_HI = 1'h1;

  typedef enum logic [2:0] {
    D_POR, D_RECFG, D_LOAD, D_DONE, D_INIT, D_USER
  } psc_dev_e;

  typedef enum logic [2:0] {
    H_IDLE, H_TRIG, H_WSTAT, H_SEND, H_EXTRA, H_WINIT, H_DONE
  } psc_host_e;
endpackage

// file: pkg/psc_if.sv
interface psc_if;
  import psc_pkg::*;
  // Host drives
  logic trig_o;
  logic trig_oe;
  logic clk_o;
  logic clk_oe;
  logic hdat_o;
  logic hdat_oe;
  // Device drives
  logic stat_o;
  logic stat_oe;
  logic done_o;
  logic done_oe;
  logic init_o;
  logic init_oe;
  logic ddat_o;
  logic ddat_oe;
  // Resolved pins, pulled up when nobody drives
  logic reconfig_trigger_n;
  logic status_n;
  logic load_complete;
  logic init_done;
  logic cfg_bit_clock;
  logic cfg_serial_in;

  assign reconfig_trigger_n = trig_oe ? trig_o : PIN_HI;
  assign status_n = stat_oe ? stat_o : PIN_HI;
  assign load_complete = done_oe ? done_o : PIN_HI;
  assign init_done = init_oe ? init_o : PIN_HI;
  assign cfg_bit_clock = clk_oe ? clk_o : PIN_HI;
  assign cfg_serial_in = hdat_oe ? hdat_o : (ddat_oe ? ddat_o : PIN_HI);

  modport dev (
    input reconfig_trigger_n, cfg_bit_clock, cfg_serial_in,
    output stat_o, stat_oe, done_o, done_oe, init_o, init_oe, ddat_o, ddat_oe
  );
  modport host (
    input status_n, load_complete, init_done,
    output trig_o, trig_oe, clk_o, clk_oe, hdat_o, hdat_oe
  );
endinterface

// file: hdl/psc_dev.sv
module psc_dev
  import psc_pkg::*;
#(
  parameter int CFG_BITS_P = CFG_BITS,
  parameter int POR_CYC_P = POR_CYC,
  parameter int INIT_CYC_P = INIT_CYC
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Configuration link
  psc_if.dev link,
  // User side
  input wire logic user_io_out,
  output logic user_io_in,
  output logic user_mode,
  output logic [CFG_BITS_P-1:0] cfg_image
);
  localparam int CW = $clog2(POR_CYC_P + CFG_BITS_P + INIT_CYC_P + 1);
  localparam int IW = $clog2(CFG_BITS_P);

  // Synchronisers for {trigger, clock, data}
  logic [2:0] s1_q;
  logic [2:0] s1_d;
  logic [2:0] s2_q;
  logic [2:0] s2_d;
  logic lclk_prev_q;
  logic lclk_prev_d;

  always_comb begin
    s1_d = {link.reconfig_trigger_n, link.cfg_bit_clock, link.cfg_serial_in};
    s2_d = s1_q;
    lclk_prev_d = s2_q[1];
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_q <= 3'h7;
      s2_q <= 3'h7;
      lclk_prev_q <= 1'h1;
    end else begin
      s1_q <= s1_d;
      s2_q <= s2_d;
      lclk_prev_q <= lclk_prev_d;
    end
  end

  logic trig_n;
  logic lclk_rise;
  logic lclk_fall;
  logic bit_in;

  always_comb begin
    trig_n = s2_q[2];
    lclk_rise = s2_q[1] & ~lclk_prev_q;
    lclk_fall = ~s2_q[1] & lclk_prev_q;
    bit_in = s2_q[0];
  end

  // Sequencer
  psc_dev_e st_q;
  psc_dev_e st_d;
  logic [CW-1:0] cnt_q;
  logic [CW-1:0] cnt_d;
  logic [CFG_BITS_P-1:0] img_q;
  logic [CFG_BITS_P-1:0] img_d;

  always_comb begin
    st_d = st_q;
    cnt_d = cnt_q;
    img_d = img_q;
    unique case (st_q)
      D_POR: begin
        if (cnt_q == CW'(POR_CYC_P - 1)) begin
          st_d = D_LOAD;
          cnt_d = '0;
        end else begin
          cnt_d = cnt_q + 1'h1;
        end
      end
      D_RECFG: begin
        if (trig_n) begin
          st_d = D_LOAD;
          cnt_d = '0;
          img_d = '0;
        end
      end
      D_LOAD: begin
        if (lclk_rise) begin
          // Bit index equals arrival order
          img_d[cnt_q[IW-1:0]] = bit_in;
          cnt_d = cnt_q + 1'h1;
          if (cnt_q == CW'(CFG_BITS_P - 1)) begin
            st_d = D_DONE;
            cnt_d = '0;
          end
        end
      end
      D_DONE: begin
        // The first fall ends the last data period, so two extra make three
        if (lclk_fall) begin
          if (cnt_q == CW'(EXTRA_FALLS)) begin
            st_d = D_INIT;
            cnt_d = '0;
          end else begin
            cnt_d = cnt_q + 1'h1;
          end
        end
      end
      D_INIT: begin
        if (cnt_q == CW'(INIT_CYC_P - 1)) begin
          st_d = D_USER;
          cnt_d = '0;
        end else begin
          cnt_d = cnt_q + 1'h1;
        end
      end
      D_USER: begin
        // Bit clock activity has no effect here
        st_d = D_USER;
      end
    endcase
    // Hold is never cut short; a trigger held past its end restarts at once, no status blip
    if (!trig_n && (st_q != D_POR || st_d != D_POR)) begin
      st_d = D_RECFG;
      cnt_d = '0;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= D_POR;
      cnt_q <= '0;
      img_q <= '0;
    end else begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      img_q <= img_d;
    end
  end

  // Pin drivers, all registered
  logic stat_oe_q;
  logic stat_oe_d;
  logic done_oe_q;
  logic done_oe_d;
  logic init_oe_q;
  logic init_oe_d;
  logic ddat_oe_q;
  logic ddat_oe_d;
  logic ddat_o_q;
  logic ddat_o_d;
  logic od_lo_q;
  logic um_q;
  logic um_d;
  logic uin_q;
  logic uin_d;
  logic init_loaded;

  always_comb begin
    init_loaded = (st_d != D_LOAD) || (cnt_d > CW'(OPT_INIT_IDX));
    stat_oe_d = (st_d == D_POR) || (st_d == D_RECFG);
    done_oe_d = (st_d == D_POR) || (st_d == D_RECFG) || (st_d == D_LOAD);
    init_oe_d = img_d[OPT_INIT_IDX] && init_loaded &&
                ((st_d == D_LOAD) || (st_d == D_DONE) || (st_d == D_INIT));
    um_d = (st_d == D_USER);
    // Data pin is only driven as user output when the image asks for it
    ddat_oe_d = um_d && img_d[OPT_UIO_IDX];
    ddat_o_d = user_io_out;
    uin_d = bit_in;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      stat_oe_q <= 1'h1;
      done_oe_q <= 1'h1;
      init_oe_q <= 1'h0;
      ddat_oe_q <= 1'h0;
      ddat_o_q <= 1'h0;
      od_lo_q <= 1'h0;
      um_q <= 1'h0;
      uin_q <= 1'h1;
    end else begin
      stat_oe_q <= stat_oe_d;
      done_oe_q <= done_oe_d;
      init_oe_q <= init_oe_d;
      ddat_oe_q <= ddat_oe_d;
      ddat_o_q <= ddat_o_d;
      od_lo_q <= PIN_LO;
      um_q <= um_d;
      uin_q <= uin_d;
    end
  end

  assign link.stat_o = od_lo_q;
  assign link.stat_oe = stat_oe_q;
  assign link.done_o = od_lo_q;
  assign link.done_oe = done_oe_q;
  assign link.init_o = od_lo_q;
  assign link.init_oe = init_oe_q;
  assign link.ddat_o = ddat_o_q;
  assign link.ddat_oe = ddat_oe_q;
  assign user_mode = um_q;
  assign user_io_in = uin_q;
  assign cfg_image = img_q;
endmodule

// file: hdl/psc_host.sv
module psc_host
  import psc_pkg::*;
#(
  parameter int W = BYTE_W,
  parameter int DEPTH = FIFO_DEPTH,
  parameter int HALF_P = LINK_HALF_CYC,
  parameter int TRIG_CYC_P = TRIG_CYC
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Configuration link
  psc_if.host link,
  // Control
  input wire logic start,
  output logic busy,
  output logic cfg_ok,
  output logic cfg_err,
  // Bitstream bytes, LSB sent first
  input wire logic [W-1:0] data_in,
  input wire logic data_valid,
  output logic data_ready
);
  localparam int PW = $clog2(2 * HALF_P + TRIG_CYC_P + 1);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int NW = $clog2(DEPTH + 1);
  localparam int BW = $clog2(W + 1);

  // Synchronisers for {status, load complete, init done}
  logic [2:0] s1_q;
  logic [2:0] s2_q;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      // Pin levels while the device is held in reset
      s1_q <= 3'h1;
      s2_q <= 3'h1;
    end else begin
      s1_q <= {link.status_n, link.load_complete, link.init_done};
      s2_q <= s1_q;
    end
  end

  // Two-entry buffer; a full buffer drops data_ready
  logic [W-1:0] mem_q [DEPTH];
  logic [AW-1:0] wr_q;
  logic [AW-1:0] wr_d;
  logic [AW-1:0] rd_q;
  logic [AW-1:0] rd_d;
  logic [NW-1:0] n_q;
  logic [NW-1:0] n_d;
  logic rdy_q;
  logic rdy_d;
  logic push;
  logic pop;

  // Sequencer
  psc_host_e st_q;
  psc_host_e st_d;
  logic [PW-1:0] ph_q;
  logic [PW-1:0] ph_d;
  logic run_q;
  logic run_d;
  logic [W-1:0] sh_q;
  logic [W-1:0] sh_d;
  logic [BW-1:0] bits_q;
  logic [BW-1:0] bits_d;
  logic [1:0] xc_q;
  logic [1:0] xc_d;
  logic ok_q;
  logic ok_d;
  logic err_q;
  logic err_d;
  logic period_end;

  always_comb begin
    push = data_valid && rdy_q;
    pop = 1'h0;
    st_d = st_q;
    ph_d = ph_q;
    run_d = run_q;
    sh_d = sh_q;
    bits_d = bits_q;
    xc_d = xc_q;
    ok_d = ok_q;
    err_d = err_q;
    period_end = run_q && (ph_q == PW'(2 * HALF_P - 1));
    if (run_q) begin
      ph_d = period_end ? '0 : ph_q + 1'h1;
      run_d = !period_end;
    end
    unique case (st_q)
      H_IDLE, H_DONE: begin
        if (start) begin
          st_d = H_TRIG;
          ph_d = '0;
          ok_d = 1'h0;
          err_d = 1'h0;
        end
      end
      H_TRIG: begin
        ph_d = ph_q + 1'h1;
        if (ph_q == PW'(TRIG_CYC_P - 1)) begin
          st_d = H_WSTAT;
          ph_d = '0;
          bits_d = '0;
        end
      end
      H_WSTAT: begin
        if (s2_q[2]) begin
          st_d = H_SEND;
        end
      end
      H_SEND: begin
        if (period_end) begin
          sh_d = sh_q >> 1;
          bits_d = bits_q - 1'h1;
        end
        if (!run_q) begin
          if (s2_q[1]) begin
            st_d = H_EXTRA;
            xc_d = '0;
          end else if (bits_q != '0) begin
            run_d = 1'h1;
          end else if (n_q != '0) begin
            sh_d = mem_q[rd_q];
            bits_d = BW'(W);
            pop = 1'h1;
          end
        end
      end
      H_EXTRA: begin
        if (!run_q) begin
          run_d = 1'h1;
        end else if (period_end) begin
          xc_d = xc_q + 1'h1;
          if (xc_q == 2'(EXTRA_FALLS - 1)) begin
            st_d = H_WINIT;
          end
        end
      end
      H_WINIT: begin
        if (s2_q[0]) begin
          st_d = H_DONE;
          ok_d = 1'h1;
        end
      end
    endcase
    // Status dropping mid-load means the device gave up
    if ((st_q == H_SEND || st_q == H_EXTRA) && !s2_q[2]) begin
      st_d = H_IDLE;
      run_d = 1'h0;
      err_d = 1'h1;
    end
    wr_d = push ? ((wr_q == AW'(DEPTH - 1)) ? '0 : wr_q + 1'h1) : wr_q;
    rd_d = pop ? ((rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + 1'h1) : rd_q;
    n_d = NW'(n_q + NW'(push) - NW'(pop));
    rdy_d = (n_d != NW'(DEPTH));
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= H_IDLE;
      ph_q <= '0;
      run_q <= 1'h0;
      sh_q <= '0;
      bits_q <= '0;
      xc_q <= '0;
      ok_q <= 1'h0;
      err_q <= 1'h0;
      wr_q <= '0;
      rd_q <= '0;
      n_q <= '0;
      rdy_q <= 1'h0;
    end else begin
      st_q <= st_d;
      ph_q <= ph_d;
      run_q <= run_d;
      sh_q <= sh_d;
      bits_q <= bits_d;
      xc_q <= xc_d;
      ok_q <= ok_d;
      err_q <= err_d;
      wr_q <= wr_d;
      rd_q <= rd_d;
      n_q <= n_d;
      rdy_q <= rdy_d;
    end
  end

  always_ff @(posedge clk) begin
    if (push) begin
      mem_q[wr_q] <= data_in;
    end
  end

  // Pin drivers, all registered
  logic trig_oe_q;
  logic clk_q;
  logic clk_oe_q;
  logic dat_q;
  logic dat_oe_q;
  logic od_lo_q;
  logic busy_q;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      trig_oe_q <= 1'h0;
      clk_q <= 1'h0;
      clk_oe_q <= 1'h0;
      dat_q <= 1'h0;
      dat_oe_q <= 1'h0;
      od_lo_q <= 1'h0;
      busy_q <= 1'h0;
    end else begin
      trig_oe_q <= (st_d == H_TRIG);
      // Clock is driven from the first cycle after reset, low when idle; it floats (pulled high) during reset
      clk_oe_q <= 1'h1;
      clk_q <= run_d && (ph_d >= PW'(HALF_P));
      // Data changes only while the clock is low
      dat_q <= sh_d[0];
      dat_oe_q <= (st_d == H_SEND);
      od_lo_q <= PIN_LO;
      busy_q <= (st_d != H_IDLE) && (st_d != H_DONE);
    end
  end

  assign link.trig_o = od_lo_q;
  assign link.trig_oe = trig_oe_q;
  assign link.clk_o = clk_q;
  assign link.clk_oe = clk_oe_q;
  assign link.hdat_o = dat_q;
  assign link.hdat_oe = dat_oe_q;
  assign busy = busy_q;
  assign cfg_ok = ok_q;
  assign cfg_err = err_q;
  assign data_ready = rdy_q;
endmodule

// file: tb/psc_link_monitor.sv
module psc_link_monitor #(
  parameter int CFG_BITS_P = 64
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Resolved pins
  input wire logic reconfig_trigger_n,
  input wire logic status_n,
  input wire logic load_complete,
  input wire logic init_done,
  input wire logic cfg_bit_clock,
  // Pin drivers
  input wire logic clk_oe,
  input wire logic hdat_o,
  input wire logic hdat_oe,
  input wire logic ddat_oe
);
  timeunit 1ns;
  timeprecision 100ps;
  logic ck_q;
  logic [7:0] rise_q;
  logic [7:0] fall_q;
  // Saturating edge counts; rises restart with the trigger, falls with load-complete
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ck_q <= 1'h1;
      rise_q <= 8'h0;
      fall_q <= 8'h0;
    end else begin
      ck_q <= cfg_bit_clock;
      if (!reconfig_trigger_n) rise_q <= 8'h0;
      else if (cfg_bit_clock && !ck_q && rise_q != 8'hff) rise_q <= rise_q + 8'h1;
      if (!load_complete) fall_q <= 8'h0;
      else if (!cfg_bit_clock && ck_q && fall_q != 8'hff) fall_q <= fall_q + 8'h1;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  property p_por_hold; $rose(rst_n) |-> (!status_n)[*8]; endproperty
  a_por_hold: assert property (p_por_hold) else $error("status left hold early");
  property p_lc_low; $rose(rst_n) |-> (!load_complete)[*8]; endproperty
  a_lc_low: assert property (p_lc_low) else $error("load complete high at power-up");
  property p_user_high; load_complete && reconfig_trigger_n |-> status_n; endproperty
  a_user_high: assert property (p_user_high) else $error("status low in user mode");
  property p_restart;
    $fell(reconfig_trigger_n) && status_n |-> ##[1:8] (!status_n && !load_complete);
  endproperty
  a_restart: assert property (p_restart) else $error("trigger did not restart");
  property p_bits; $rose(load_complete) |-> rise_q >= CFG_BITS_P; endproperty
  a_bits: assert property (p_bits) else $error("load complete before all bits");
  property p_extra; $rose(init_done) |-> fall_q >= 2; endproperty
  a_extra: assert property (p_extra) else $error("init ended without two falls");
  property p_init_low; $fell(init_done) |-> !load_complete; endproperty
  a_init_low: assert property (p_init_low) else $error("init pin fell after loading");
  property p_clk_held; load_complete |-> clk_oe; endproperty
  a_clk_held: assert property (p_clk_held) else $error("bit clock left floating");
  property p_data_free; ddat_oe |-> load_complete && !hdat_oe; endproperty
  a_data_free: assert property (p_data_free) else $error("data pin contention");
  property p_data_stable; hdat_oe && cfg_bit_clock && !ck_q |-> $stable(hdat_o); endproperty
  a_data_stable: assert property (p_data_stable) else $error("data moved at rise");
  c_loaded: cover property ($rose(load_complete));
  c_init: cover property ($rose(init_done));
  c_reconfig: cover property ($fell(reconfig_trigger_n) && status_n);
endmodule

// file: tb/passive_serial_config_load_tb_top.sv
module passive_serial_config_load_tb_top import psc_pkg::*;;
  timeunit 1ns;
  timeprecision 100ps;
  // Four bytes, so the two-entry buffer fills and must refuse
  localparam int NB = 32;
  logic clk = 1'h0;
  logic rst_n = 1'h0;
  logic start = 1'h0;
  logic data_valid = 1'h0;
  logic user_io_out = 1'h0;
  logic [7:0] data_in = 8'h0;
  logic busy, cfg_ok, cfg_err, data_ready, user_io_in, user_mode, um_q;
  logic [NB-1:0] cfg_image;
  logic [NB-1:0] exp_q[$];
  int n_mismatch = 0;
  int n_compared = 0;
  int cyc = 0;
  psc_if link_if();
  psc_dev #(.CFG_BITS_P(NB), .POR_CYC_P(20), .INIT_CYC_P(16)) psc_dev_inst (
    .clk(clk), .rst_n(rst_n), .link(link_if), .user_io_out(user_io_out),
    .user_io_in(user_io_in), .user_mode(user_mode), .cfg_image(cfg_image));
  psc_host psc_host_inst (
    .clk(clk), .rst_n(rst_n), .link(link_if), .start(start), .busy(busy),
    .cfg_ok(cfg_ok), .cfg_err(cfg_err), .data_in(data_in), .data_valid(data_valid),
    .data_ready(data_ready));
  psc_link_monitor #(.CFG_BITS_P(NB)) psc_link_monitor_inst (
    .clk(clk), .rst_n(rst_n), .reconfig_trigger_n(link_if.reconfig_trigger_n),
    .status_n(link_if.status_n), .load_complete(link_if.load_complete),
    .init_done(link_if.init_done), .cfg_bit_clock(link_if.cfg_bit_clock),
    .clk_oe(link_if.clk_oe), .hdat_o(link_if.hdat_o), .hdat_oe(link_if.hdat_oe),
    .ddat_oe(link_if.ddat_oe));
  initial begin
    forever #12.5 clk = ~clk;
  end
  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic print_verdict();
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // Bytes go LSB first; random gaps, and the slow drain makes the buffer refuse
  task automatic load(input logic [NB-1:0] img);
    int i;
    start <= 1'h1;
    @(posedge clk);
    start <= 1'h0;
    exp_q.push_back(img);
    for (i = 0; i < NB / 8; i++) begin
      data_in <= img[i*8+:8];
      data_valid <= 1'h1;
      do @(posedge clk); while (data_ready !== 1'b1);
      if ($urandom % 2) begin
        data_valid <= 1'h0;
        repeat (1 + $urandom % 12) @(posedge clk);
      end
    end
    data_valid <= 1'h0;
    chk(busy, 1'h1);
    chk(user_mode, 1'h0);
    chk(link_if.load_complete, 1'h0);
    for (i = 0; i < 4000 && cfg_ok !== 1'b1; i++) @(posedge clk);
    chk(cfg_ok, 1'h1);
    chk(cfg_err, 1'h0);
    chk(busy, 1'h0);
    repeat (40) @(posedge clk);
  endtask
  // Image and link pins are judged on the cycle user mode is entered
  always @(posedge clk) begin
    um_q <= user_mode;
    if (user_mode === 1'b1 && um_q === 1'b0) begin
      if (exp_q.size() == 0) chk(1'h1, 1'h0);
      else chk(cfg_image, exp_q.pop_front());
      chk({link_if.status_n, link_if.load_complete, link_if.reconfig_trigger_n}, 3'h7);
    end
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_mismatch++;
      print_verdict();
    end
  end
  initial begin
    logic [NB-1:0] img;
    logic v;
    int m;
    void'($urandom(32'h7e23_253d));
    repeat (16) @(posedge clk);
    rst_n <= 1'h1;
    repeat (5) @(posedge clk);
    chk(link_if.status_n, 1'h0);
    chk(link_if.load_complete, 1'h0);
    // Every combination of init pin enable and user data pin
    for (m = 3; m >= 0; m--) begin
      img = NB'($urandom);
      img[1:0] = m[1:0];
      load(img);
      chk(user_mode, 1'h1);
      repeat (2) begin
        v = 1'($urandom);
        user_io_out <= v;
        repeat (8) @(posedge clk);
        chk(link_if.cfg_serial_in, m[1] ? v : 1'h1);
        chk(user_io_in, m[1] ? v : 1'h1);
      end
    end
    print_verdict();
  end
endmodule
